/* File: inc/cap_pkg.sv */
package cap_pkg;

    // bus shape
    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 32;

    // register byte offsets
    localparam logic [11:0] DEV_CAP_OFS     = 12'h084;
    localparam logic [11:0] SLOT_CAP_OFS    = 12'h094;
    localparam logic [11:0] SLOT_STAT_OFS   = 12'h098;

    // device capabilities fields
    localparam int          L0S_LSB         = 6;
    localparam int          L1_LSB          = 9;
    localparam int          LAT_W           = 3;

    // slot capabilities fields
    localparam int          PLIM_LSB        = 7;
    localparam int          PLIM_W          = 8;
    localparam int          PSCL_LSB        = 15;
    localparam int          PSCL_W          = 2;
    localparam int          SNUM_LSB        = 19;
    localparam int          SNUM_W          = 13;

    // slot status fields
    localparam int          ST_INIT_BIT     = 0;
    localparam int          ST_MSG_BIT      = 1;
    localparam int          ST_WAKE_BIT     = 2;
    localparam int          ST_LPM_BIT      = 3;
    localparam int          ST_CNT_LSB      = 8;
    localparam int          CNT_W           = 8;

    // values after reset
    localparam logic [1:0]  PSCL_RST        = 2'h0;
    localparam logic [7:0]  PLIM_RST        = 8'h00;
    localparam logic [7:0]  CNT_RST         = 8'h00;

    // power scale codes
    typedef enum logic [1:0] {
        SCALE_1     = 2'h0,
        SCALE_0P1   = 2'h1,
        SCALE_0P01  = 2'h2,
        SCALE_0P001 = 2'h3
    } pwr_scale_t;

    // L0s acceptable latency codes
    typedef enum logic [2:0] {
        L0S_64NS  = 3'h0,
        L0S_128NS = 3'h1,
        L0S_256NS = 3'h2,
        L0S_512NS = 3'h3,
        L0S_1US   = 3'h4,
        L0S_2US   = 3'h5,
        L0S_4US   = 3'h6,
        L0S_NONE  = 3'h7
    } l0s_lat_t;

    // L1 acceptable latency codes
    typedef enum logic [2:0] {
        L1_1US   = 3'h0,
        L1_2US   = 3'h1,
        L1_4US   = 3'h2,
        L1_8US   = 3'h3,
        L1_16US  = 3'h4,
        L1_32US  = 3'h5,
        L1_64NS  = 3'h6,
        L1_NONE  = 3'h7
    } l1_lat_t;

    // init sequencer
    typedef enum logic [1:0] {
        ST_INIT = 2'h1,
        ST_RUN  = 2'h2
    } init_st_t;

endpackage

/* File: design/slot_and_pm_capability_fields.sv */
// Our own choice: register access over APB.
`timescale 1ns/1ns
`default_nettype none
module slot_and_pm_capability_fields #(
    parameter bit                  ROOT_PORT = 1'b1,
    parameter bit                  SLOT_EN   = 1'b1,
    parameter cap_pkg::pwr_scale_t PWR_SCALE = cap_pkg::SCALE_1,
    parameter logic [7:0]          PWR_LIMIT = 8'h19,
    parameter logic [12:0]         SLOT_NUM  = 13'h0001,
    parameter cap_pkg::l0s_lat_t   L0S_LAT   = cap_pkg::L0S_64NS,
    parameter cap_pkg::l1_lat_t    L1_LAT    = cap_pkg::L1_1US
) (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rstn,
    // apb slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [cap_pkg::ADDR_W-1:0] paddr,
    input  wire logic [cap_pkg::DATA_W-1:0] pwdata,
    input  wire logic [3:0]                 pstrb,
    output logic                            pready,
    output logic      [cap_pkg::DATA_W-1:0] prdata,
    output logic                            pslverr,
    // set slot power limit message
    output logic                            msg_valid,
    input  wire logic                       msg_ready,
    output logic      [7:0]                 msg_limit,
    output logic      [1:0]                 msg_scale
);
    import cap_pkg::*;

    // slot register present
    localparam bit SLOT_ON = ROOT_PORT && SLOT_EN;

    init_st_t         st_q;
    logic [7:0]       plim_q;
    logic [1:0]       pscl_q;
    logic             pend_q;
    logic [7:0]       msg_limit_q;
    logic [1:0]       msg_scale_q;
    logic [CNT_W-1:0] cnt_q;
    logic [31:0]      prdata_q;
    logic             pslverr_q;
    logic             setup;
    logic             wr_acc;
    logic             hit_slot;
    logic             msg_take;

    // address decode
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a, input bit slot);
        is_mapped = (a == DEV_CAP_OFS) || (slot && (a == SLOT_CAP_OFS)) ||
                    (slot && (a == SLOT_STAT_OFS));
    endfunction

    assign setup    = psel && !penable;
    assign wr_acc   = psel && penable && pwrite;
    assign hit_slot = SLOT_ON && (paddr == SLOT_CAP_OFS);
    assign msg_take = pend_q && msg_ready;
    assign pready   = 1'b1;

    // init sequencer
    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_q <= ST_INIT;
        end else begin
            case (st_q)
                ST_INIT: st_q <= ST_RUN;
                ST_RUN:  st_q <= ST_RUN;
                default: st_q <= ST_INIT;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pscl_q <= PSCL_RST;
            plim_q <= PLIM_RST;
        end else if (st_q == ST_INIT && SLOT_ON) begin
            pscl_q <= PWR_SCALE;
            plim_q <= PWR_LIMIT;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pend_q <= 1'b0;
        end else if (wr_acc && hit_slot && st_q == ST_RUN) begin
            pend_q <= 1'b1;
        end else if (msg_take) begin
            pend_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            msg_limit_q <= PLIM_RST;
            msg_scale_q <= PSCL_RST;
        end else if (wr_acc && hit_slot && st_q == ST_RUN) begin
            msg_limit_q <= plim_q;
            msg_scale_q <= pscl_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_q <= CNT_RST;
        end else if (msg_take) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    // read data captured in setup
    always_ff @(posedge clk) begin
        if (!rstn) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= !is_mapped(paddr, SLOT_ON);
            case (paddr)
                DEV_CAP_OFS: begin
                    if (!ROOT_PORT) begin
                        prdata_q[L0S_LSB +: LAT_W] <= L0S_LAT;
                        prdata_q[L1_LSB +: LAT_W]  <= L1_LAT;
                    end
                end
                SLOT_CAP_OFS: begin
                    if (SLOT_ON) begin
                        prdata_q[PLIM_LSB +: PLIM_W] <= plim_q;
                        prdata_q[PSCL_LSB +: PSCL_W] <= pscl_q;
                        prdata_q[SNUM_LSB +: SNUM_W] <= (st_q == ST_RUN) ? SLOT_NUM : 13'h0000;
                    end
                end
                SLOT_STAT_OFS: begin
                    if (SLOT_ON) begin
                        prdata_q[ST_INIT_BIT]            <= (st_q == ST_RUN);
                        prdata_q[ST_MSG_BIT]             <= pend_q;
                        prdata_q[ST_WAKE_BIT]            <= 1'b0;
                        prdata_q[ST_LPM_BIT]             <= 1'b0;
                        prdata_q[ST_CNT_LSB +: CNT_W]    <= cnt_q;
                    end
                end
                default: prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign prdata    = prdata_q;
    assign pslverr   = pslverr_q;
    assign msg_valid = pend_q;
    assign msg_limit = msg_limit_q;
    assign msg_scale = msg_scale_q;

endmodule
`default_nettype wire

/* File: dv/msg_sink.sv */
`timescale 1ns/1ns
`default_nettype none
module msg_sink (
    // clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // message side
    input  wire logic msg_valid,
    output logic      msg_ready,
    // bench control
    input  wire logic go,
    output int        taken
);
    always_ff @(posedge clk) begin
        msg_ready <= rstn & go;
        if (!rstn) begin
            taken <= 0;
        end else if (msg_valid && msg_ready) begin
            taken <= taken + 1;
        end
    end
endmodule
`default_nettype wire

/* File: dv/slot_and_pm_capability_fields_props.sv */
`timescale 1ns/1ns
`default_nettype none
module slot_and_pm_capability_fields_props #(parameter bit ROOT_PORT = 1'b1) (
    input wire logic        clk, rstn, psel, penable, pwrite, pslverr, msg_valid, msg_ready,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic [7:0]  msg_limit,
    input wire logic [1:0]  msg_scale
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic setup, wr;
    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite;
    a_msg_on_write: assert property (ROOT_PORT && wr && paddr == 12'h094 |=> msg_valid)
        else $error("no message after slot write");
    a_msg_held: assert property (msg_valid && !msg_ready |=> msg_valid && $stable({msg_limit, msg_scale}))
        else $error("message dropped or changed");
    a_msg_taken: assert property (msg_valid && msg_ready && !wr |=> !msg_valid)
        else $error("message still pending");
    a_reset_clear: assert property (disable iff (1'b0) !rstn |=> !msg_valid && {msg_scale, msg_limit} == 10'h000)
        else $error("reset values wrong");
    a_unmapped_err: assert property (setup && !(paddr == 12'h084 || ROOT_PORT && (paddr == 12'h094 || paddr == 12'h098))
        |=> pslverr && prdata == 32'h0)
        else $error("unmapped access accepted");
    a_devcap_rsvd: assert property (setup && paddr == 12'h084 |=> !pslverr && prdata[31:12] == 20'h0 && prdata[5:0] == 6'h0)
        else $error("device cap reserved bits set");
    a_root_lat_off: assert property (ROOT_PORT && setup && paddr == 12'h084 |=> prdata[11:6] == 6'h0)
        else $error("latency fields on in root mode");
    a_slot_rsvd: assert property (ROOT_PORT && setup && paddr == 12'h094 |=> !pslverr && prdata[18:17] == 2'h0)
        else $error("slot cap layout wrong");
    a_no_wake: assert property (ROOT_PORT && setup && paddr == 12'h098 |=> prdata[3:2] == 2'h0)
        else $error("wake or low power reported");
endmodule
bind slot_and_pm_capability_fields slot_and_pm_capability_fields_props #(.ROOT_PORT(ROOT_PORT)) props_inst (.clk, .rstn,
    .psel, .penable, .pwrite, .pslverr, .msg_valid, .msg_ready, .paddr, .prdata, .msg_limit, .msg_scale);
`default_nettype wire

/* File: dv/slot_and_pm_capability_fields_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module slot_and_pm_capability_fields_tb;
    import cap_pkg::*;
    logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
    logic        rdy, er, ee, mv, mr, mv_e;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prd_r, prd_e, r_d, r_e, x;
    logic [7:0]  ml;
    logic [1:0]  ms;
    int          error_cnt = 0, compares = 0, seed = 32'h8f33, i, taken;
    slot_and_pm_capability_fields #(.PWR_SCALE(SCALE_0P01), .PWR_LIMIT(8'hA5), .SLOT_NUM(13'h1FFF), .L0S_LAT(L0S_2US))
        slot_and_pm_capability_fields_inst (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF),
        .pready(rdy), .prdata(prd_r), .pslverr(er), .msg_valid(mv), .msg_ready(mr), .msg_limit(ml), .msg_scale(ms));
    slot_and_pm_capability_fields #(.ROOT_PORT(1'b0), .L0S_LAT(L0S_NONE), .L1_LAT(L1_64NS))
        ep_slot_and_pm_capability_fields_inst (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF),
        .pready(), .prdata(prd_e), .pslverr(ee), .msg_valid(mv_e), .msg_ready(mr), .msg_limit(), .msg_scale());
    msg_sink msg_sink_inst (.clk, .rstn, .msg_valid(mv), .msg_ready(mr), .go, .taken);
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        r_d = prd_r;
        r_e = prd_e;
        x = {30'h0, ee, er};
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s exp %h got %h", s, e, g);
        end
    endtask
    function automatic logic [31:0] slot_word(logic [12:0] n, logic [1:0] s, logic [7:0] l);
        return {n, 2'h0, s, l, 7'h00};
    endfunction
    task automatic give_verdict();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        error_cnt++;
        give_verdict();
    end
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1;
        apb(0, 12'h094, 0);
        chk("slot_pre", 32'h0, r_d);
        $display("test reset done");
        apb(1, 12'h084, 32'hFFFFFFFF);
        apb(0, 12'h084, 0);
        chk("lat_ep", {20'h0, L1_64NS, L0S_NONE, 6'h0}, r_e);
        chk("lat_root", 32'h0, r_d);
        apb(0, 12'h094, 0);
        chk("slot", slot_word(13'h1FFF, SCALE_0P01, 8'hA5), r_d);
        chk("slot_ep_err", 32'h2, x);
        apb(0, 12'h098, 0);
        chk("status", 32'h1, r_d);
        $display("test fields done");
        apb(1, 12'h094, $random(seed));
        apb(1, 12'h094, $random(seed));
        chk("msg", {21'h0, 1'b1, 2'h2, 8'hA5}, {21'h0, mv, ms, ml});
        chk("msg_ep", 32'h0, {31'h0, mv_e});
        apb(0, 12'h094, 0);
        chk("slot_kept", slot_word(13'h1FFF, SCALE_0P01, 8'hA5), r_d);
        go <= 1;
        for (i = 0; i < 20 && taken == 0; i++) @(posedge clk);
        go <= 0;
        repeat (2) @(posedge clk);
        chk("taken", 32'h1, taken);
        apb(0, 12'h098, 0);
        chk("status_cnt", 32'h101, r_d);
        $display("test message done");
        for (i = 0; i < 16; i++) begin
            x = $random(seed) & 32'hFFC;
            if (x[11:0] inside {12'h084, 12'h094, 12'h098}) x = 32'hA0;
            apb(i[0], x[11:0], $random(seed));
            chk("unmapped_err", 32'h1, {31'h0, er});
            chk("unmapped_data", 32'h0, r_d);
        end
        $display("test unmapped done");
        give_verdict();
    end
endmodule
`default_nettype wire
